// ===== design/sadc_regs.svh
// What this block does
// R1: Conversion takes sixteen converter clock cycles.
// R2: Status write starts conversion at next edge.
// R3: Late start waits an edge; seventeen worst.
// R4: Continuous mode overwrites result every conversion.
// R5: Continuous mode restarts until software clears it.
// R6: Continuous, no interrupts: flag sets once only.
// R7: Single mode: one conversion per status write.
// R8: Result scales linearly, saturates at full scale.
// R9: Interrupt enabled: request at every conversion end.
// R10: Request only while the done bit is 0.
// R11: Result read or status write clears request.
// R12: No interrupts: flag read-only, cleared by access.
// R13: Reset clears bits, channel all ones, off.
// R14: Channel codes: six pins, high, low reference.
// R15: All-ones channel powers converter off entirely.
// R16: Software waits one period after power-up.
// R17: Selected pin forced input, port writes ignored.
// R18: Used pin reads 0, or latch if output.
// R19: Wait mode: conversion and interrupt keep working.
// R20: Stop mode aborts conversion; continuous mode resumes after exit.
// R21: Software waits one period after stop exit.
// R22: Eight-bit result register loaded per conversion.
// R23: Divider codes give 1, 2, 4, 8, 16.
// R24: Source bit 1 bus clock, 0 crystal reference.
// R25: Software keeps clock settings during conversion.
// R26: Reserved channel completes and loads zero.
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

`define SADC_OFS_STATUS    8'h3C
`define SADC_OFS_RESULT    8'h40
`define SADC_OFS_CLOCK     8'h44

`define SADC_BIT_DONE      7
`define SADC_BIT_IEN       6
`define SADC_BIT_CONT      5
`define SADC_CHAN_HI       4
`define SADC_CHAN_LO       0
`define SADC_DIV_HI        7
`define SADC_DIV_LO        5
`define SADC_BIT_SRC       4

`define SADC_STATUS_RST    8'h1F
`define SADC_CLOCK_RST     8'h00
`define SADC_CHAN_OFF      5'h1F
`define SADC_CHAN_REFH     5'h1D
`define SADC_CHAN_REFL     5'h1E
`define SADC_CHAN_LAST_EXT 5'h05

`define SADC_CONV_CYCLES   16
`define SADC_SAMPLE_CYCLES 8
`define SADC_DIV_MAX_LOG   4

`endif

// ===== design/sadc_pkg.sv
package sadc_pkg;

  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_WAIT = 2'b01,
    SADC_CONV = 2'b11
  } sadc_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sadc_wb_req_t;

  typedef struct packed {
    logic       powerOn;
    logic [4:0] channel;
    logic       sample;
    logic [7:0] dac;
  } sadc_ana_t;

endpackage : sadc_pkg

// ===== design/sadc_clk_div.sv
`timescale 1ns/10ps
`include "sadc_regs.svh"

module sadc_clk_div (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       srcSel,
  input  wire logic [2:0] divCode,
  input  wire logic       crystalRefClock,
  output logic            convTick
);

  logic       refPrev_r;
  logic [3:0] divCnt_r;
  logic       srcEdge;
  logic [3:0] divLast;

  // The crystal reference is sampled as a plain input; its rising edge is one source tick.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      refPrev_r <= 1'b0;
    else
      refPrev_r <= crystalRefClock;
  end

  assign srcEdge = srcSel ? 1'b1 : (crystalRefClock & ~refPrev_r); // R24

  always_comb
  begin
    if (divCode[2])
      divLast = 4'hF; // R23
    else
      divLast = 4'((5'h01 << divCode[1:0]) - 5'h01); // R23
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt_r <= 4'h0;
      convTick <= 1'b0;
    end
    else
    begin
      convTick <= 1'b0;
      if (srcEdge)
      begin
        if (divCnt_r >= divLast)
        begin
          divCnt_r <= 4'h0;
          convTick <= 1'b1;
        end
        else
          divCnt_r <= divCnt_r + 4'h1;
      end
    end
  end

endmodule : sadc_clk_div

// ===== design/sadc_top.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
`include "sadc_regs.svh"

module sadc_top #(
  parameter int NUM_PINS = 6
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  sadc_pkg::sadc_wb_req_t     wbReq,
  output logic [31:0]                wbDatO,
  output logic                       wbAckO,
  output logic                       convIrq,
  input  wire logic                  stopMode,
  input  wire logic                  crystalRefClock,
  input  wire logic                  anaCmp,
  output sadc_pkg::sadc_ana_t        anaOut,
  input  wire logic [NUM_PINS-1:0]   portDataLatch,
  input  wire logic [NUM_PINS-1:0]   portDir,
  input  wire logic [NUM_PINS-1:0]   padIn,
  output logic [NUM_PINS-1:0]        padOut,
  output logic [NUM_PINS-1:0]        padOe,
  output logic [NUM_PINS-1:0]        portReadData
);

  sadc_pkg::sadc_state_t state_r;
  sadc_pkg::sadc_state_t state_nxt;

  logic       irqEnable_r;
  logic       contMode_r;
  logic [4:0] channel_r;
  logic       doneFlag_r;
  logic       irqPend_r;
  logic       firstDone_r;
  logic [7:0] result_r;
  logic [2:0] divCode_r;
  logic       srcSel_r;
  logic [3:0] cycCnt_r;
  logic [7:0] sar_r;
  logic       stopPrev_r;

  logic       convTick;
  logic       busReq;
  logic       statusWr;
  logic       clockWr;
  logic       resultRd;
  logic       poweredOff;
  logic       convDone;
  logic [7:0] sarBitNow;
  logic [7:0] sarNew;
  logic [7:0] finalCode;
  logic       stopEntry;

  // Channel decode is needed by the result path; the pin override compares channel_r with its pin number instead.
  function automatic logic isExternal(input logic [4:0] chan);
    isExternal = (chan <= `SADC_CHAN_LAST_EXT);
  endfunction : isExternal

  function automatic logic isReserved(input logic [4:0] chan);
    isReserved = !isExternal(chan) && (chan != `SADC_CHAN_REFH) &&
                 (chan != `SADC_CHAN_REFL) && (chan != `SADC_CHAN_OFF);
  endfunction : isReserved

  function automatic logic [7:0] trialMask(input logic [3:0] cnt);
    if (cnt >= 4'(`SADC_SAMPLE_CYCLES))
      trialMask = 8'h80 >> (cnt - 4'(`SADC_SAMPLE_CYCLES));
    else
      trialMask = 8'h00;
  endfunction : trialMask

  sadc_clk_div u_clk_div (
    .clk             (clk),
    .rst_n           (rst_n),
    .srcSel          (srcSel_r),
    .divCode         (divCode_r),
    .crystalRefClock (crystalRefClock),
    .convTick        (convTick)
  );

  // Bus side: an access takes effect at the edge where the acknowledge is raised.
  assign busReq   = wbReq.cyc & wbReq.stb & ~wbAckO;
  assign statusWr = busReq & wbReq.we & wbReq.sel[0] & (wbReq.adr == `SADC_OFS_STATUS);
  assign clockWr  = busReq & wbReq.we & wbReq.sel[0] & (wbReq.adr == `SADC_OFS_CLOCK);
  assign resultRd = busReq & ~wbReq.we & (wbReq.adr == `SADC_OFS_RESULT);

  assign poweredOff = (channel_r == `SADC_CHAN_OFF); // R15
  assign stopEntry  = stopMode & ~stopPrev_r;

  assign sarBitNow = trialMask(cycCnt_r);
  assign sarNew    = anaCmp ? (sar_r | sarBitNow) : sar_r;
  assign finalCode = isReserved(channel_r) ? 8'h00 : sarNew; // R26 R8
  assign convDone  = (state_r == sadc_pkg::SADC_CONV) && convTick &&
                     (cycCnt_r == 4'(`SADC_CONV_CYCLES - 1)) && !stopMode; // R1

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wbAckO <= 1'b0;
    else
      wbAckO <= busReq;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wbDatO <= 32'h0000_0000;
    else if (busReq && !wbReq.we)
    begin
      unique case (wbReq.adr)
        `SADC_OFS_STATUS: wbDatO <= {24'h00_0000, doneFlag_r, irqEnable_r, contMode_r, channel_r};
        `SADC_OFS_RESULT: wbDatO <= {24'h00_0000, result_r}; // R22
        `SADC_OFS_CLOCK:  wbDatO <= {24'h00_0000, divCode_r, srcSel_r, 4'h0};
        default:          wbDatO <= 32'h0000_0000;
      endcase
    end
    else
      wbDatO <= 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqEnable_r <= 1'b0; // R13
      contMode_r  <= 1'b0; // R13
      channel_r   <= 5'(`SADC_STATUS_RST); // R13
    end
    else if (statusWr)
    begin
      irqEnable_r <= wbReq.dat[`SADC_BIT_IEN];
      contMode_r  <= wbReq.dat[`SADC_BIT_CONT]; // R5
      channel_r   <= wbReq.dat[`SADC_CHAN_HI:`SADC_CHAN_LO]; // R14
    end
  end

  // Changing these mid-conversion corrupts the result; software must avoid it.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCode_r <= 3'(`SADC_CLOCK_RST >> `SADC_DIV_LO);
      srcSel_r  <= 1'b0; // R24
    end
    else if (clockWr)
    begin
      divCode_r <= wbReq.dat[`SADC_DIV_HI:`SADC_DIV_LO]; // R23
      srcSel_r  <= wbReq.dat[`SADC_BIT_SRC]; // R24
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stopPrev_r <= 1'b0;
    else
      stopPrev_r <= stopMode;
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      sadc_pkg::SADC_IDLE:
      begin
        if (statusWr && (wbReq.dat[`SADC_CHAN_HI:`SADC_CHAN_LO] != `SADC_CHAN_OFF))
          state_nxt = sadc_pkg::SADC_WAIT; // R2 R7
        else if (!stopMode && stopPrev_r && contMode_r && !poweredOff)
          state_nxt = sadc_pkg::SADC_WAIT; // R20
      end
      sadc_pkg::SADC_WAIT:
      begin
        if (convTick)
          state_nxt = sadc_pkg::SADC_CONV; // R2 R3
      end
      sadc_pkg::SADC_CONV:
      begin
        if (convDone && !contMode_r)
          state_nxt = sadc_pkg::SADC_IDLE; // R7
      end
      default:
        state_nxt = sadc_pkg::SADC_IDLE;
    endcase
    // A status write restarts, even in the middle of a conversion, unless it selects the off code or stop mode is set.
    if (statusWr && state_r != sadc_pkg::SADC_IDLE)
      state_nxt = sadc_pkg::SADC_WAIT; // R2
    if (statusWr && (wbReq.dat[`SADC_CHAN_HI:`SADC_CHAN_LO] == `SADC_CHAN_OFF))
      state_nxt = sadc_pkg::SADC_IDLE; // R15
    if (stopMode)
      state_nxt = sadc_pkg::SADC_IDLE; // R20
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= sadc_pkg::SADC_IDLE;
    else
      state_r <= state_nxt;
  end

  // Successive approximation: eight sampling cycles, then one trial bit per cycle, MSB first.
  // A stop abort clears the partial code, so a resumed conversion never inherits stale trial bits.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cycCnt_r <= 4'h0;
      sar_r    <= 8'h00;
    end
    else if (stopEntry)
    begin
      cycCnt_r <= 4'h0; // R20
      sar_r    <= 8'h00;
    end
    else if (state_nxt == sadc_pkg::SADC_CONV && state_r == sadc_pkg::SADC_WAIT)
    begin
      cycCnt_r <= 4'h0; // R1
      sar_r    <= 8'h00;
    end
    else if (state_r == sadc_pkg::SADC_CONV && convTick)
    begin
      if (convDone)
      begin
        cycCnt_r <= 4'h0; // R5
        sar_r    <= 8'h00;
      end
      else
      begin
        cycCnt_r <= cycCnt_r + 4'h1;
        sar_r    <= sarNew;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      anaOut <= '{powerOn: 1'b0, channel: `SADC_CHAN_OFF, sample: 1'b0, dac: 8'h00};
    else
    begin
      anaOut.powerOn <= !poweredOff && !stopMode; // R15 R20
      anaOut.channel <= channel_r; // R14
      if (state_nxt != sadc_pkg::SADC_CONV)
      begin
        anaOut.sample <= 1'b0;
        anaOut.dac    <= 8'h00;
      end
      else if (state_r != sadc_pkg::SADC_CONV || convDone)
      begin
        anaOut.sample <= 1'b1;
        anaOut.dac    <= 8'h00;
      end
      else if (convTick)
      begin
        anaOut.sample <= (cycCnt_r + 4'h1) < 4'(`SADC_SAMPLE_CYCLES);
        anaOut.dac    <= sarNew | trialMask(cycCnt_r + 4'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      result_r <= 8'h00;
    else if (convDone)
      result_r <= finalCode; // R4 R22 R26
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      firstDone_r <= 1'b0;
    else if (statusWr)
      firstDone_r <= 1'b0;
    else if (convDone)
      firstDone_r <= 1'b1; // R6
  end

  // The done flag: a conversion end in the same cycle as a clearing access wins.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      doneFlag_r <= 1'b0; // R13
    else if (convDone && !irqEnable_r && !(contMode_r && firstDone_r && !statusWr))
      doneFlag_r <= 1'b1; // R6 R12
    else if (statusWr)
      doneFlag_r <= wbReq.dat[`SADC_BIT_IEN] & wbReq.dat[`SADC_BIT_DONE]; // R10 R12
    else if (resultRd && !irqEnable_r)
      doneFlag_r <= 1'b0; // R12
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irqPend_r <= 1'b0;
    else if (convDone && irqEnable_r && !doneFlag_r && !statusWr)
      irqPend_r <= 1'b1; // R9 R10
    else if (statusWr || resultRd || !irqEnable_r)
      irqPend_r <= 1'b0; // R11
  end

  // The request stays live in wait mode so it can wake the processor.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      convIrq <= 1'b0;
    else
      convIrq <= irqPend_r && !doneFlag_r; // R10 R19
  end

  genvar pin;
  generate
    for (pin = 0; pin < NUM_PINS; pin++)
    begin : g_pin
      logic pinUsed;
      logic padOut_r;
      logic padOe_r;
      logic portRead_r;
      assign pinUsed = !poweredOff && (channel_r == 5'(pin));

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          padOut_r   <= 1'b0;
          padOe_r    <= 1'b0;
          portRead_r <= 1'b0;
        end
        else
        begin
          padOut_r <= portDataLatch[pin];
          padOe_r  <= portDir[pin] && !pinUsed; // R17
          if (pinUsed)
            portRead_r <= portDir[pin] & portDataLatch[pin]; // R18
          else
            portRead_r <= portDir[pin] ? portDataLatch[pin] : padIn[pin];
        end
      end

      assign padOut[pin]       = padOut_r;
      assign padOe[pin]        = padOe_r;
      assign portReadData[pin] = portRead_r;
    end
  endgenerate

endmodule : sadc_top

// ===== dv/sadc_assertions.sv
`timescale 1ns/10ps
`include "sadc_regs.svh"
module sadc_assertions #(
  parameter int NUM_PINS = 6
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input sadc_pkg::sadc_wb_req_t   wbReq,
  input wire logic                wbAckO,
  input wire logic                convIrq,
  input wire logic                stopMode,
  input sadc_pkg::sadc_ana_t      anaOut,
  input wire logic [NUM_PINS-1:0] portDataLatch,
  input wire logic [NUM_PINS-1:0] portDir,
  input wire logic [NUM_PINS-1:0] padOe,
  input wire logic [NUM_PINS-1:0] portReadData
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [NUM_PINS-1:0] latchDir_r;
  logic [2:0]          pin;
  logic                inUse;
  logic [3:0]          smpLen_r;
  logic                abortReq;
  assign abortReq = stopMode || (wbReq.cyc && wbReq.stb && wbReq.we && wbReq.sel[0] && !wbAckO &&
                                 wbReq.adr == `SADC_OFS_STATUS);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      smpLen_r <= 4'h0;
    else if (!anaOut.sample)
      smpLen_r <= 4'h0;
    else if (smpLen_r != 4'hF)
      smpLen_r <= smpLen_r + 4'h1;
  end
  assign pin = anaOut.channel[2:0];
  assign inUse = anaOut.channel <= `SADC_CHAN_LAST_EXT && !stopMode;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      latchDir_r <= '0;
    else
      latchDir_r <= portDir & portDataLatch;
  end
  property p_ack;
    wbReq.cyc && wbReq.stb && !wbAckO |=> wbAckO ##1 !wbAckO;
  endproperty
  a_ack: assert property (p_ack) else $error("ack is not one pulse");
  property p_rst;
    $rose(rst_n) |-> anaOut.channel == `SADC_CHAN_OFF && !convIrq && !anaOut.powerOn;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_off;
    (anaOut.channel == `SADC_CHAN_OFF) [*2] |-> !anaOut.powerOn && !anaOut.sample;
  endproperty
  a_off: assert property (p_off) else $error("converter on at off code");
  property p_stop;
    stopMode [*2] |-> !anaOut.powerOn && !anaOut.sample;
  endproperty
  a_stop: assert property (p_stop) else $error("converter active in stop");
  property p_pin;
    inUse ##1 (inUse && $stable(anaOut.channel)) |-> !padOe[pin];
  endproperty
  a_pin: assert property (p_pin) else $error("selected pin driven");
  property p_prd;
    inUse ##1 (inUse && $stable(anaOut.channel)) |-> portReadData[pin] == latchDir_r[pin];
  endproperty
  a_prd: assert property (p_prd) else $error("selected pin read wrong");
  property p_clr;
    wbAckO && wbReq.we && wbReq.sel[0] && wbReq.adr == `SADC_OFS_STATUS |=> !convIrq;
  endproperty
  a_clr: assert property (p_clr) else $error("request kept after write");
  property p_smp;
    $fell(anaOut.sample) && !$past(abortReq) |-> smpLen_r >= 4'h8;
  endproperty
  a_smp: assert property (p_smp) else $error("sampling too short");
  property p_dac;
    anaOut.sample |-> anaOut.dac == 8'h00;
  endproperty
  a_dac: assert property (p_dac) else $error("trial code while sampling");
endmodule : sadc_assertions

bind sadc_top sadc_assertions #(.NUM_PINS(NUM_PINS)) u_chk (
  .clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbAckO(wbAckO), .convIrq(convIrq),
  .stopMode(stopMode), .anaOut(anaOut), .portDataLatch(portDataLatch),
  .portDir(portDir), .padOe(padOe), .portReadData(portReadData));

// ===== dv/sadc_ana_model.sv
`timescale 1ns/10ps
module sadc_ana_model (
  input wire logic           clk,
  input sadc_pkg::sadc_ana_t anaOut,
  input wire logic [7:0]     extLevel,
  output logic               anaCmp
);
  logic [7:0] level;
  logic       noise_r = 1'h0;
  always @(posedge clk)
  begin
    noise_r <= ~noise_r;
  end
  // An unpowered or unmapped input has no level, so the comparator just toggles.
  always_comb
  begin
    level = extLevel;
    if (anaOut.channel == 5'h1D)
      level = 8'hFF;
    if (anaOut.channel == 5'h1E)
      level = 8'h00;
    if (!anaOut.powerOn || (anaOut.channel > 5'h05 && anaOut.channel < 5'h1D))
      anaCmp = noise_r;
    else
      anaCmp = level >= anaOut.dac;
  end
endmodule : sadc_ana_model

// ===== dv/sar_adc_control_tb.sv
`timescale 1ns/10ps
module sar_adc_control_tb;
  logic                   clk = 1'h0;
  logic                   rst_n = 1'h0;
  sadc_pkg::sadc_wb_req_t wbReq = '0;
  sadc_pkg::sadc_ana_t    anaOut;
  logic [31:0]            wbDatO, rdat;
  logic                   wbAckO, convIrq, anaCmp;
  logic                   stopMode = 1'h0;
  logic                   xtal = 1'h0;
  logic [7:0]             extLevel = 8'h5A;
  logic [5:0]             portDataLatch = 6'h00, portDir = 6'h00, padIn = 6'h00;
  logic [5:0]             padOut, padOe, portReadData;
  logic [4:0]             codes [5] = '{5'h05, 5'h1D, 5'h1E, 5'h06, 5'h00};
  logic [7:0]             exps [5] = '{8'h5A, 8'hFF, 8'h00, 8'h00, 8'h5A};
  int                     mismatches = 0, n_checks = 0, cycles = 0, n;

  sadc_top u_dut (.clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbDatO(wbDatO), .wbAckO(wbAckO),
    .convIrq(convIrq), .stopMode(stopMode), .crystalRefClock(xtal), .anaCmp(anaCmp), .anaOut(anaOut),
    .portDataLatch(portDataLatch), .portDir(portDir), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .portReadData(portReadData));
  sadc_ana_model u_ana (.clk(clk), .anaOut(anaOut), .extLevel(extLevel), .anaCmp(anaCmp));

  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    xtal <= ~xtal;
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wbReq <= '{1'h1, 1'h1, we, a, 4'hF, {24'h000000, d}};
    @(posedge clk);
    while (wbAckO !== 1'h1)
      @(posedge clk);
    rdat = wbDatO;
    wbReq <= '0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask : rd

  // Sampling lasts eight converter ticks, so its length in clocks shows the divide ratio.
  task automatic span(input logic [2:0] code, input logic src, input int exp);
    wr(8'h44, {code, src, 4'h0});
    wr(8'h3C, 8'h00);
    while (anaOut.sample !== 1'h1)
      @(posedge clk);
    n = 0;
    while (anaOut.sample === 1'h1)
    begin
      @(posedge clk);
      n++;
    end
    chk(n, exp);
    wr(8'h3C, 8'h1F);
  endtask : span

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h3C, 8'h1F);
    rd(8'h44, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h50, 8'h00);
    span(3'h0, 1'h0, 16);
    for (int i = 0; i < 6; i++)
      span((i == 5) ? 3'h7 : i[2:0], 1'h1, 8 << ((i > 3) ? 4 : i));
    wr(8'h44, 8'h10);
    wr(8'h3C, 8'h06);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h3C, {3'h0, codes[i]});
      repeat (20) @(posedge clk);
      rd(8'h3C, {3'h4, codes[i]});
      rd(8'h40, exps[i]);
      rd(8'h3C, {3'h0, codes[i]});
    end
    wr(8'h3C, 8'h00);
    repeat (14) @(posedge clk);
    rd(8'h3C, 8'h00);
    rd(8'h3C, 8'h80);
    repeat (40) @(posedge clk);
    rd(8'h3C, 8'h80);
    extLevel <= 8'h33;
    wr(8'h3C, 8'h20);
    repeat (20) @(posedge clk);
    rd(8'h3C, 8'hA0);
    rd(8'h40, 8'h33);
    extLevel <= 8'h66;
    repeat (40) @(posedge clk);
    rd(8'h3C, 8'h20);
    rd(8'h40, 8'h66);
    wr(8'h3C, 8'h40);
    repeat (20) @(posedge clk);
    chk(convIrq, 1'h1);
    rd(8'h3C, 8'h40);
    rd(8'h40, 8'h66);
    @(posedge clk);
    chk(convIrq, 1'h0);
    wr(8'h3C, 8'hC0);
    repeat (20) @(posedge clk);
    chk(convIrq, 1'h0);
    rd(8'h3C, 8'hC0);
    wr(8'h3C, 8'h60);
    repeat (20) @(posedge clk);
    rd(8'h40, 8'h66);
    repeat (20) @(posedge clk);
    chk(convIrq, 1'h1);
    wr(8'h3C, 8'h00);
    repeat (5) @(posedge clk);
    stopMode <= 1'h1;
    repeat (30) @(posedge clk);
    chk(anaOut.powerOn, 1'h0);
    stopMode <= 1'h0;
    repeat (30) @(posedge clk);
    rd(8'h3C, 8'h00);
    wr(8'h3C, 8'h20);
    repeat (5) @(posedge clk);
    stopMode <= 1'h1;
    repeat (10) @(posedge clk);
    stopMode <= 1'h0;
    repeat (40) @(posedge clk);
    rd(8'h3C, 8'hA0);
    wr(8'h3C, 8'h02);
    portDir <= 6'h3F;
    portDataLatch <= 6'h2A;
    padIn <= 6'h15;
    repeat (3) @(posedge clk);
    chk(padOe, 6'h3B);
    chk(padOut, 6'h2A);
    chk(portReadData, 6'h2A);
    portDir <= 6'h00;
    repeat (3) @(posedge clk);
    chk(portReadData, 6'h11);
    finish_test();
  end
endmodule : sar_adc_control_tb
